// >>> src/sspc_pkg.sv
// Shared constants and types for the serial port control block.
package sspc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int SSPC_AW = 3;
	localparam int SSPC_DW = 8;
	localparam logic [2:0] SSPC_ADDR_CTRL1 = 3'h0;
	localparam logic [2:0] SSPC_ADDR_CTRL2 = 3'h1;
	localparam logic [2:0] SSPC_ADDR_BUF = 3'h2;
	localparam logic [2:0] SSPC_ADDR_RELOAD = 3'h3;
	localparam logic [2:0] SSPC_ADDR_IRQ_STAT = 3'h4;
	localparam logic [2:0] SSPC_ADDR_IRQ_MASK = 3'h5;

	localparam logic [7:0] SSPC_RST_CTRL1 = 8'h00;
	localparam logic [7:0] SSPC_RST_CTRL2 = 8'h00;
	localparam logic [7:0] SSPC_RST_RELOAD = 8'h00;
	localparam logic [7:0] SSPC_RST_BUF = 8'h00;

	// Bit positions inside the first control register.
	localparam int SSPC_B_WRITE_COLLISION_FLAG = 7;
	localparam int SSPC_B_OVF = 6;

	// ----------------------------------------------------------------
	// Interrupt status layout
	// ----------------------------------------------------------------
	localparam int SSPC_IRQ_W = 5;
	localparam int SSPC_IRQ_RX = 0;
	localparam int SSPC_IRQ_WRITE_COLLISION_FLAG = 1;
	localparam int SSPC_IRQ_OVF = 2;
	localparam int SSPC_IRQ_START = 3;
	localparam int SSPC_IRQ_STOP = 4;
	localparam logic [4:0] SSPC_RST_IRQ = 5'h00;

	// ----------------------------------------------------------------
	// Mode selector codes and rate figures
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		SSPC_SPI_M_DIV4 = 4'h0,
		SSPC_SPI_M_DIV16 = 4'h1,
		SSPC_SPI_M_DIV64 = 4'h2,
		SSPC_SPI_M_TMR = 4'h3,
		SSPC_SPI_S_SS = 4'h4,
		SSPC_SPI_S_NOSS = 4'h5,
		SSPC_I2C_S7 = 4'h6,
		SSPC_I2C_S10 = 4'h7,
		SSPC_I2C_M_RLD = 4'h8,
		SSPC_SPI_M_RLD = 4'ha,
		SSPC_I2C_M_FW = 4'hb,
		SSPC_I2C_S7_SP = 4'he,
		SSPC_I2C_S10_SP = 4'hf
	} sspc_mode_t;

	localparam int SSPC_CW = 11;
	localparam logic [10:0] SSPC_DIV4 = 11'h004;
	localparam logic [10:0] SSPC_DIV16 = 11'h010;
	localparam logic [10:0] SSPC_DIV64 = 11'h040;
	localparam logic [10:0] SSPC_RLD_MUL = 11'h004;

	typedef struct packed {
		logic write_collision_flag;
		logic ovf;
		logic en;
		logic clock_polarity_release;
		logic [3:0] mode;
	} sspc_ctrl1_t;

endpackage : sspc_pkg

// >>> src/sspc_rate.sv
// Bit-rate enable generator for the serial port master modes.
`timescale 1ns/1ps
`default_nettype none
module sspc_rate
	import sspc_pkg::*;
#(
	parameter int CW = SSPC_CW
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	input wire logic [3:0] mode,
	input wire logic [7:0] reload,
	input wire logic timer_tick,
	output logic tick
);

	logic [CW-1:0] period;
	logic [CW-1:0] cnt_q;
	logic tmr_half_q;

	// ----------------------------------------------------------------
	// Period select
	// ----------------------------------------------------------------
	always_comb begin
		case (mode)
			SSPC_SPI_M_DIV4: period = CW'(SSPC_DIV4);
			SSPC_SPI_M_DIV16: period = CW'(SSPC_DIV16);
			SSPC_SPI_M_DIV64: period = CW'(SSPC_DIV64);
			default: period = CW'(SSPC_RLD_MUL * ({3'h0, reload} + 11'h001));
		endcase
	end

	// Timer mode halves the timer pulses; other modes count system clocks.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
			tmr_half_q <= 1'b0;
			tick <= 1'b0;
		end else if (!run) begin
			cnt_q <= '0;
			tmr_half_q <= 1'b0;
			tick <= 1'b0;
		end else if (mode == SSPC_SPI_M_TMR) begin
			cnt_q <= '0;
			if (timer_tick) begin
				tmr_half_q <= !tmr_half_q;
			end
			tick <= timer_tick && tmr_half_q;
		end else if (cnt_q >= period - CW'(1)) begin
			cnt_q <= '0;
			tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q + CW'(1);
			tick <= 1'b0;
		end
	end

endmodule : sspc_rate
`default_nettype wire

// >>> src/sspc_top.sv
// Control and status logic of the dual SPI / I2C synchronous serial port.
//
// How it works
// R01 - Slave load while previous word still shifting sets write collision flag.
// R02 - I2C master load while bus cannot start a transmission sets collision.
// R03 - SPI slave byte arriving while buffer still unread sets receive overflow flag.
// R04 - Slave software must read the buffer after every byte to avoid overflow.
// R05 - SPI master operation never sets the receive overflow flag.
// R06 - I2C byte arriving while buffer still full sets receive overflow flag.
// R07 - Port enable hands the serial pins to the port; clear returns them.
// R08 - In SPI the polarity bit sets the idle clock level.
// R09 - In I2C slave polarity one releases clock, zero holds it low.
// R10 - Mode selects SPI master rates, timer rate, or slave with/without select.
// R11 - Separate mode codes give I2C slave with 7-bit or 10-bit addressing.
// R12 - Extra I2C slave codes also raise start and stop interrupts.
// R13 - Reload rate is clock over four times reload plus one; low values banned.
// R14 - Software must set pin directions properly while the port is enabled.
// R15 - Software must never write the reserved mode codes.
`timescale 1ns/1ps
`default_nettype none
module sspc_top
	import sspc_pkg::*;
(
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic [SSPC_AW-1:0] ADDR,
	input wire logic [SSPC_DW-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [SSPC_DW-1:0] RDATA,
	output logic IRQ,
	input wire logic SHIFT_BUSY,
	input wire logic RX_DONE,
	input wire logic [SSPC_DW-1:0] RX_BYTE,
	input wire logic I2C_BUS_IDLE,
	input wire logic START_DET,
	input wire logic STOP_DET,
	input wire logic TIMER_TICK,
	output logic BIT_TICK,
	output logic TX_LOAD,
	output logic [SSPC_DW-1:0] TX_BYTE,
	output logic SPI_PINS_EN,
	output logic SS_PIN_EN,
	output logic I2C_PINS_EN,
	output logic SCK_IDLE_LEVEL,
	output logic SCL_OUT,
	output logic SCL_OE_N,
	output logic [SSPC_DW-1:0] CTRL2
);

	sspc_ctrl1_t ctrl1_q;
	sspc_ctrl1_t ctrl1_d;
	logic [7:0] reload_q;
	logic [7:0] buf_q;
	logic buf_full_q;
	logic [SSPC_IRQ_W-1:0] stat_q;
	logic [SSPC_IRQ_W-1:0] mask_q;
	logic [SSPC_IRQ_W-1:0] stat_set;
	logic [7:0] rd_mux;

	logic is_spi_m, is_spi_s, is_i2c_s, is_i2c_m, is_spi, is_i2c, sp_irq, slave;
	logic wr_ctrl1, wr_buf, rd_buf;
	logic write_collision_flag_set, ovf_set, rx_load, rate_run;

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	// R10 mode classes
	always_comb begin
		is_spi_m = 1'b0;
		is_spi_s = 1'b0;
		is_i2c_s = 1'b0;
		is_i2c_m = 1'b0;
		sp_irq = 1'b0;
		case (ctrl1_q.mode)
			SSPC_SPI_M_DIV4, SSPC_SPI_M_DIV16, SSPC_SPI_M_DIV64, SSPC_SPI_M_TMR, SSPC_SPI_M_RLD: begin
				is_spi_m = 1'b1;
			end
			SSPC_SPI_S_SS, SSPC_SPI_S_NOSS: begin
				is_spi_s = 1'b1;
			end
			// R11 seven and ten bit slave
			SSPC_I2C_S7, SSPC_I2C_S10: begin
				is_i2c_s = 1'b1;
			end
			// R12 slave with start and stop events
			SSPC_I2C_S7_SP, SSPC_I2C_S10_SP: begin
				is_i2c_s = 1'b1;
				sp_irq = 1'b1;
			end
			SSPC_I2C_M_RLD, SSPC_I2C_M_FW: begin
				is_i2c_m = 1'b1;
			end
			// Reserved codes leave the port in no mode at all.
			default: begin
				is_spi_m = 1'b0;
			end
		endcase
	end

	assign is_spi = is_spi_m || is_spi_s;
	assign is_i2c = is_i2c_m || is_i2c_s;
	assign slave = is_spi_s || is_i2c_s;

	// ----------------------------------------------------------------
	// Bus decode and flag events
	// ----------------------------------------------------------------
	assign wr_ctrl1 = WR && (ADDR == SSPC_ADDR_CTRL1);
	assign wr_buf = WR && (ADDR == SSPC_ADDR_BUF);
	assign rd_buf = RD && (ADDR == SSPC_ADDR_BUF);

	// R01 slave collision
	// R02 master bus busy collision
	assign write_collision_flag_set = wr_buf && ctrl1_q.en && ((slave && SHIFT_BUSY) || (is_i2c_m && !I2C_BUS_IDLE));

	// R03 SPI slave overflow
	// R05 master excluded
	// R06 I2C overflow
	assign ovf_set = RX_DONE && ctrl1_q.en && buf_full_q && (is_spi_s || is_i2c);
	assign rx_load = RX_DONE && ctrl1_q.en && !buf_full_q;

	// ----------------------------------------------------------------
	// Control register one
	// ----------------------------------------------------------------
	// Software may only clear the two flags; a set in the same cycle wins.
	always_comb begin
		ctrl1_d = ctrl1_q;
		if (wr_ctrl1) begin
			ctrl1_d = sspc_ctrl1_t'(WDATA);
			ctrl1_d.write_collision_flag = ctrl1_q.write_collision_flag && WDATA[SSPC_B_WRITE_COLLISION_FLAG];
			ctrl1_d.ovf = ctrl1_q.ovf && WDATA[SSPC_B_OVF];
		end
		if (write_collision_flag_set) begin
			ctrl1_d.write_collision_flag = 1'b1;
		end
		if (ovf_set) begin
			ctrl1_d.ovf = 1'b1;
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ctrl1_q <= sspc_ctrl1_t'(SSPC_RST_CTRL1);
		end else begin
			ctrl1_q <= ctrl1_d;
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			CTRL2 <= SSPC_RST_CTRL2;
			reload_q <= SSPC_RST_RELOAD;
			mask_q <= SSPC_RST_IRQ;
		end else if (WR) begin
			if (ADDR == SSPC_ADDR_CTRL2) begin
				CTRL2 <= WDATA;
			end
			if (ADDR == SSPC_ADDR_RELOAD) begin
				reload_q <= WDATA;
			end
			if (ADDR == SSPC_ADDR_IRQ_MASK) begin
				mask_q <= WDATA[SSPC_IRQ_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Transfer buffer
	// ----------------------------------------------------------------
	// An overflowing byte is dropped so the unread one is kept intact.
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			buf_q <= SSPC_RST_BUF;
			buf_full_q <= 1'b0;
		end else begin
			if (rx_load) begin
				buf_q <= RX_BYTE;
			end
			buf_full_q <= rx_load || (buf_full_q && !rd_buf);
		end
	end

	// A colliding load is not passed to the shifter.
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			TX_LOAD <= 1'b0;
			TX_BYTE <= SSPC_RST_BUF;
		end else begin
			TX_LOAD <= wr_buf && ctrl1_q.en && !write_collision_flag_set;
			if (wr_buf && ctrl1_q.en && !write_collision_flag_set) begin
				TX_BYTE <= WDATA;
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	always_comb begin
		stat_set = '0;
		stat_set[SSPC_IRQ_RX] = rx_load;
		stat_set[SSPC_IRQ_WRITE_COLLISION_FLAG] = write_collision_flag_set;
		stat_set[SSPC_IRQ_OVF] = ovf_set;
		// R12 start and stop events
		stat_set[SSPC_IRQ_START] = START_DET && ctrl1_q.en && sp_irq;
		stat_set[SSPC_IRQ_STOP] = STOP_DET && ctrl1_q.en && sp_irq;
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			stat_q <= SSPC_RST_IRQ;
			IRQ <= 1'b0;
		end else begin
			if (WR && (ADDR == SSPC_ADDR_IRQ_STAT)) begin
				stat_q <= stat_set | (stat_q & ~WDATA[SSPC_IRQ_W-1:0]);
			end else begin
				stat_q <= stat_set | stat_q;
			end
			IRQ <= |(stat_q & mask_q);
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_comb begin
		case (ADDR)
			SSPC_ADDR_CTRL1: rd_mux = ctrl1_q;
			SSPC_ADDR_CTRL2: rd_mux = CTRL2;
			SSPC_ADDR_BUF: rd_mux = buf_q;
			SSPC_ADDR_RELOAD: rd_mux = reload_q;
			SSPC_ADDR_IRQ_STAT: rd_mux = {3'h0, stat_q};
			SSPC_ADDR_IRQ_MASK: rd_mux = {3'h0, mask_q};
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			RDATA <= 8'h00;
		end else begin
			RDATA <= RD ? rd_mux : 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Pin ownership and clock line
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			SPI_PINS_EN <= 1'b0;
			SS_PIN_EN <= 1'b0;
			I2C_PINS_EN <= 1'b0;
			SCK_IDLE_LEVEL <= 1'b0;
			SCL_OUT <= 1'b1;
			SCL_OE_N <= 1'b1;
		end else begin
			// R07 pin takeover
			SPI_PINS_EN <= ctrl1_q.en && is_spi;
			SS_PIN_EN <= ctrl1_q.en && (ctrl1_q.mode == SSPC_SPI_S_SS);
			I2C_PINS_EN <= ctrl1_q.en && is_i2c;
			// R08 idle clock level
			SCK_IDLE_LEVEL <= ctrl1_q.clock_polarity_release;
			// R09 clock stretch hold
			SCL_OUT <= !(ctrl1_q.en && is_i2c_s && !ctrl1_q.clock_polarity_release);
			SCL_OE_N <= !(ctrl1_q.en && is_i2c_s && !ctrl1_q.clock_polarity_release);
		end
	end

	// ----------------------------------------------------------------
	// Bit rate
	// ----------------------------------------------------------------
	// R10 master rates
	// R13 reload rate
	assign rate_run = ctrl1_q.en && (is_spi_m || ctrl1_q.mode == SSPC_I2C_M_RLD);

	sspc_rate #(
		.CW(SSPC_CW)
	) u_rate (
		.clk(CLK),
		.rst(SYS_RST),
		.run(rate_run),
		.mode(ctrl1_q.mode),
		.reload(reload_q),
		.timer_tick(TIMER_TICK),
		.tick(BIT_TICK)
	);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SYS_RST);

	logic div4_run;
	logic rld1_run;
	assign div4_run = rate_run && (ctrl1_q.mode == SSPC_SPI_M_DIV4);
	assign rld1_run = rate_run && (ctrl1_q.mode == SSPC_SPI_M_RLD) && (reload_q == 8'h01);

	sequence s_slave_busy_load;
		wr_buf && ctrl1_q.en && is_spi_s && SHIFT_BUSY;
	endsequence

	property p_write_collision_flag_slave;
		s_slave_busy_load |=> ctrl1_q.write_collision_flag && stat_q[SSPC_IRQ_WRITE_COLLISION_FLAG] && !TX_LOAD;
	endproperty
	a_write_collision_flag_slave: assert property (p_write_collision_flag_slave) else $error("slave collision not flagged"); // R01

	property p_write_collision_flag_i2cm;
		wr_buf && ctrl1_q.en && is_i2c_m && !I2C_BUS_IDLE |=> ctrl1_q.write_collision_flag;
	endproperty
	a_write_collision_flag_i2cm: assert property (p_write_collision_flag_i2cm) else $error("master collision not flagged"); // R02

	property p_ovf_spi;
		RX_DONE && ctrl1_q.en && is_spi_s && buf_full_q |=> ctrl1_q.ovf && buf_q == $past(buf_q);
	endproperty
	a_ovf_spi: assert property (p_ovf_spi) else $error("SPI overflow not flagged"); // R03

	property p_ovf_master;
		ctrl1_q.en && is_spi_m && !ctrl1_q.ovf |=> !ctrl1_q.ovf;
	endproperty
	a_ovf_master: assert property (p_ovf_master) else $error("overflow raised in master mode"); // R05

	property p_ovf_i2c;
		RX_DONE && ctrl1_q.en && is_i2c && buf_full_q && !wr_ctrl1 |=> ctrl1_q.ovf ##1 ctrl1_q.ovf || $past(wr_ctrl1);
	endproperty
	a_ovf_i2c: assert property (p_ovf_i2c) else $error("I2C overflow not held"); // R06

	property p_pins;
		##1 (SPI_PINS_EN == $past(ctrl1_q.en && is_spi)) && (I2C_PINS_EN == $past(ctrl1_q.en && is_i2c));
	endproperty
	a_pins: assert property (p_pins) else $error("pin ownership wrong"); // R07

	property p_idle_level;
		ctrl1_q.en && is_spi |=> SCK_IDLE_LEVEL == $past(ctrl1_q.clock_polarity_release);
	endproperty
	a_idle_level: assert property (p_idle_level) else $error("idle clock level wrong"); // R08

	property p_stretch;
		ctrl1_q.en && is_i2c_s |=> (SCL_OE_N == $past(ctrl1_q.clock_polarity_release)) && (SCL_OUT == $past(ctrl1_q.clock_polarity_release));
	endproperty
	a_stretch: assert property (p_stretch) else $error("clock stretch control wrong"); // R09

	sequence s_div4_span;
		(div4_run && BIT_TICK) ##1 div4_run[*4];
	endsequence

	property p_div4;
		s_div4_span |-> BIT_TICK && !$past(BIT_TICK, 1) && !$past(BIT_TICK, 2) && !$past(BIT_TICK, 3);
	endproperty
	a_div4: assert property (p_div4) else $error("divide by four rate wrong"); // R10

	property p_i2c_slave_pins;
		ctrl1_q.en && (ctrl1_q.mode == SSPC_I2C_S10) |=> I2C_PINS_EN && !SPI_PINS_EN && !BIT_TICK;
	endproperty
	a_i2c_slave_pins: assert property (p_i2c_slave_pins) else $error("I2C slave mode wrong"); // R11

	property p_start_irq;
		START_DET && ctrl1_q.en && is_i2c_s && !(WR && (ADDR == SSPC_ADDR_IRQ_STAT)) |=>
			stat_q[SSPC_IRQ_START] == ($past(sp_irq) || $past(stat_q[SSPC_IRQ_START]));
	endproperty
	a_start_irq: assert property (p_start_irq) else $error("start interrupt wrong"); // R12

	sequence s_rld1_span;
		(rld1_run && BIT_TICK) ##1 rld1_run[*8];
	endsequence

	property p_reload_rate;
		s_rld1_span |-> BIT_TICK && !$past(BIT_TICK, 4) && !$past(BIT_TICK, 7);
	endproperty
	a_reload_rate: assert property (p_reload_rate) else $error("reload rate wrong"); // R13

endmodule : sspc_top
`default_nettype wire

// >>> verification/sspc_far_end.sv
// Behavioural model of the external serial device beside the port.
`timescale 1ns/1ps
`default_nettype none
module sspc_far_end
	import sspc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic tx_load,
	input wire logic send,
	input wire logic [7:0] send_byte,
	input wire logic slow,
	input wire logic bus_free,
	output logic shift_busy,
	output logic rx_done,
	output logic [7:0] rx_byte,
	output logic bus_idle
);
	logic [3:0] cnt_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 4'h0;
		end else if (tx_load) begin
			cnt_q <= slow ? 4'hf : 4'h2;
		end else if (cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
		end
	end
	assign shift_busy = (cnt_q != 4'h0);

	// one-cycle arrival pulse
	// Outside the pulse the byte lines toggle, so stale data never looks valid.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_done <= 1'b0;
			rx_byte <= 8'h00;
		end else begin
			rx_done <= send;
			rx_byte <= send ? send_byte : ~rx_byte;
		end
	end

	// bus readiness for a master start
	assign bus_idle = bus_free;
endmodule : sspc_far_end
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the serial port control block.
`timescale 1ns/1ps
`default_nettype none
module testbench
	import sspc_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic send = 1'b0, slow = 1'b0, free = 1'b1, st = 1'b0, sp = 1'b0, tt = 1'b0, rd_p = 1'b0;
	logic [7:0] sbyte = 8'h00;
	logic busy, rxd, idle_b, bt, txl, spen, ssen, i2en, sck, sclo, scloe, irq;
	logic [7:0] rdata, rxb, txb, ctrl2;
	logic [7:0] exp_q[$];
	int err_total = 0, n_tests = 0, cyc = 0, seed = 32'hd1cf;

	always #25 clk = ~clk;

	sspc_top sspc_top_i (.CLK(clk), .SYS_RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .IRQ(irq), .SHIFT_BUSY(busy), .RX_DONE(rxd), .RX_BYTE(rxb), .I2C_BUS_IDLE(idle_b),
		.START_DET(st), .STOP_DET(sp), .TIMER_TICK(tt), .BIT_TICK(bt), .TX_LOAD(txl), .TX_BYTE(txb),
		.SPI_PINS_EN(spen), .SS_PIN_EN(ssen), .I2C_PINS_EN(i2en), .SCK_IDLE_LEVEL(sck),
		.SCL_OUT(sclo), .SCL_OE_N(scloe), .CTRL2(ctrl2));

	sspc_far_end sspc_far_end_i (.clk(clk), .rst(rst), .tx_load(txl), .send(send), .send_byte(sbyte),
		.slow(slow), .bus_free(free), .shift_busy(busy), .rx_done(rxd), .rx_byte(rxb), .bus_idle(idle_b));

	// ----------------------------------------------------------------
	// Checking and bus tasks
	// ----------------------------------------------------------------
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr8(input logic [2:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		rd <= 1'b0;
		@(posedge clk);
	endtask : wr8

	task automatic rd8(input logic [2:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		addr <= a;
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clk);
	endtask : rd8

	task automatic idle(input int n);
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (n) @(posedge clk);
	endtask : idle

	task automatic look(input int n);
		idle(n);
		@(negedge clk);
	endtask : look

	task automatic rx(input logic [7:0] b);
		send <= 1'b1;
		sbyte <= b;
		@(posedge clk);
		send <= 1'b0;
		@(posedge clk);
	endtask : rx

	// The first tick after a mode change may come from the old count, so the gap is measured from it to the second.
	task automatic gap(input logic [7:0] e);
		int n;
		for (int k = 0; k < 2; k++) begin
			n = 0;
			do begin
				@(negedge clk);
				n++;
			end while (bt !== 1'b1 && n < 600);
		end
		chk(8'(n), e);
		@(posedge clk);
	endtask : gap

	// Read data belong to the cycle after the strobe, so they are judged one edge later.
	always @(posedge clk) begin
		if (rd_p) begin
			chk(rdata, exp_q.pop_front());
		end
		rd_p <= rd;
	end

	always @(posedge clk) begin
		cyc++;
		tt <= (cyc % 5 == 4);
		if (cyc == 20000) begin
			err_total++;
			final_report();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	logic [7:0] r, a, m8;
	logic is_spi, ovf;
	logic [7:0] rxm[3] = '{8'h25, 8'h26, 8'h20};
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk({sclo, scloe}, 8'h03);
		@(posedge clk);
		for (int k = 0; k < 8; k++) rd8(3'(k), 8'h00);
		r = 8'($random(seed));
		wr8(SSPC_ADDR_CTRL2, r);
		wr8(3'h6, r);
		wr8(SSPC_ADDR_IRQ_MASK, 8'hff);
		rd8(SSPC_ADDR_CTRL2, r);
		rd8(3'h6, 8'h00);
		rd8(SSPC_ADDR_IRQ_MASK, 8'h1f);
		look(2);
		chk(ctrl2, r);
		@(posedge clk);
		// pin directions are assumed set by software before enabling.
		for (int m = 0; m < 16; m++) begin
			if (m == 9 || m == 12 || m == 13) continue;
			for (int p = 0; p < 2; p++) begin
				is_spi = (m < 6 || m == 10);
				wr8(SSPC_ADDR_CTRL1, {3'b001, p[0], m[3:0]});
				look(2);
				chk(spen, is_spi);
				chk(ssen, m == 4);
				chk(i2en, !is_spi);
				if (is_spi) chk(sck, p[0]);
				if (m == 6 || m == 7 || m > 13) chk({sclo, scloe}, {2{p[0]}});
				@(posedge clk);
			end
		end
		wr8(SSPC_ADDR_CTRL1, 8'h00);
		look(2);
		chk({spen, ssen, i2en}, 8'h00);
		@(posedge clk);
		for (int m = 0; m < 4; m++) begin
			wr8(SSPC_ADDR_CTRL1, {4'h2, 4'(m)});
			idle(1);
			gap(m == 3 ? 8'd10 : 8'(4 << (2 * m)));
		end
		for (int k = 0; k < 3; k++) begin
			// reload of one only in SPI; the I2C pass keeps three or more.
			r = (k == 0) ? 8'h01 : 8'(3 + {$random(seed)} % 13);
			wr8(SSPC_ADDR_RELOAD, r);
			rd8(SSPC_ADDR_RELOAD, r);
			wr8(SSPC_ADDR_CTRL1, k == 2 ? 8'h28 : 8'h2a);
			idle(1);
			gap(8'(4 * (r + 1)));
		end
		a = 8'($random(seed));
		slow <= 1'b1;
		wr8(SSPC_ADDR_CTRL1, 8'h24);
		wr8(SSPC_ADDR_IRQ_MASK, 8'h1f);
		wr8(SSPC_ADDR_BUF, a);
		idle(0);
		@(negedge clk);
		chk({txl, txb}, {1'b1, a});
		@(posedge clk);
		wr8(SSPC_ADDR_BUF, ~a);
		idle(0);
		@(negedge clk);
		chk(txl, 1'b0);
		@(posedge clk);
		rd8(SSPC_ADDR_CTRL1, 8'ha4);
		rd8(SSPC_ADDR_IRQ_STAT, 8'h02);
		look(1);
		chk({irq, txb}, {1'b1, a});
		@(posedge clk);
		wr8(SSPC_ADDR_CTRL1, 8'h24);
		wr8(SSPC_ADDR_IRQ_STAT, 8'h1f);
		rd8(SSPC_ADDR_CTRL1, 8'h24);
		look(2);
		chk(irq, 1'b0);
		@(posedge clk);
		free <= 1'b0;
		wr8(SSPC_ADDR_CTRL1, 8'h2b);
		wr8(SSPC_ADDR_BUF, a);
		idle(0);
		@(negedge clk);
		chk(txl, 1'b0);
		@(posedge clk);
		rd8(SSPC_ADDR_CTRL1, 8'hab);
		wr8(SSPC_ADDR_CTRL1, 8'h2b);
		free <= 1'b1;
		wr8(SSPC_ADDR_BUF, a);
		idle(0);
		@(negedge clk);
		chk(txl, 1'b1);
		@(posedge clk);
		wr8(SSPC_ADDR_IRQ_MASK, 8'h00);
		foreach (rxm[i]) begin
			m8 = rxm[i];
			ovf = (m8 != 8'h20);
			wr8(SSPC_ADDR_CTRL1, m8);
			wr8(SSPC_ADDR_IRQ_STAT, 8'h1f);
			idle(1);
			a = 8'($random(seed));
			rx(a);
			rx(~a);
			idle(2);
			rd8(SSPC_ADDR_CTRL1, {1'b0, ovf, m8[5:0]});
			rd8(SSPC_ADDR_IRQ_STAT, {5'h0, ovf, 2'b01});
			rd8(SSPC_ADDR_BUF, a);
			idle(1);
			rx(8'h3c);
			idle(1);
			rd8(SSPC_ADDR_BUF, 8'h3c);
			wr8(SSPC_ADDR_CTRL1, m8);
			wr8(SSPC_ADDR_IRQ_MASK, 8'h04);
			look(2);
			chk(irq, ovf);
			@(posedge clk);
			wr8(SSPC_ADDR_IRQ_MASK, 8'h00);
		end
		wr8(SSPC_ADDR_CTRL1, 8'h2e);
		for (int k = 0; k < 2; k++) begin
			wr8(SSPC_ADDR_IRQ_STAT, 8'h1f);
			idle(0);
			st <= 1'b1;
			sp <= 1'b1;
			@(posedge clk);
			st <= 1'b0;
			sp <= 1'b0;
			idle(2);
			rd8(SSPC_ADDR_IRQ_STAT, k == 0 ? 8'h18 : 8'h00);
			wr8(SSPC_ADDR_CTRL1, 8'h26);
		end
		look(3);
		final_report();
	end
endmodule : testbench
`default_nettype wire
